/* pkg/acme_consts.vh */
`ifndef ACME_CONSTS_VH
`define ACME_CONSTS_VH

// Rule layer select codes
`define ACME_LAYER_OFF 2'h0
`define ACME_LAYER_L2 2'h1
`define ACME_LAYER_L3 2'h2
`define ACME_LAYER_L4 2'h3

// Option codes
`define ACME_OPT_0 2'h0
`define ACME_OPT_1 2'h1
`define ACME_OPT_2 2'h2
`define ACME_OPT_3 2'h3

// Table geometry
`define ACME_ENTRIES 16
`define ACME_CNT_W 11

// Matching entry field layout (entry word is 160 bits)
`define ACME_M_LAYER_HI 159
`define ACME_M_LAYER_LO 158
`define ACME_M_OPT_HI 157
`define ACME_M_OPT_LO 156
`define ACME_M_SIDE 155
`define ACME_M_POL 154
`define ACME_M_PCMODE_HI 153
`define ACME_M_PCMODE_LO 152
`define ACME_M_FLAGEN 151
`define ACME_M_A_HI 127
`define ACME_M_A_LO 80
`define ACME_M_B_HI 79
`define ACME_M_B_LO 48
`define ACME_M_C_HI 47
`define ACME_M_C_LO 16
`define ACME_M_D_HI 15
`define ACME_M_D_LO 0
`define ACME_M_W 160

// Action entry layout: [23:22] prio mode, [21:19] prio, [18] remark en,
// [17:15] remark value, [14:13] map mode, [12] time unit, [11] algo,
// [31:32-NPORTS] of the register word: port map, kept in a separate field
`define ACME_A_W 24
`define ACME_A_PM_HI 23
`define ACME_A_PM_LO 22
`define ACME_A_P_HI 21
`define ACME_A_P_LO 19
`define ACME_A_RPE 18
`define ACME_A_RP_HI 17
`define ACME_A_RP_LO 15
`define ACME_A_MM_HI 14
`define ACME_A_MM_LO 13
`define ACME_A_CNT_HI 23
`define ACME_A_CNT_LO 13
`define ACME_A_TU 12
`define ACME_A_CA 11

// Register map (word addresses on the plain port)
`define ACME_ADDR_MATCH 8'h00
`define ACME_ADDR_ACTION 8'h40
`define ACME_ADDR_SET 8'h50
`define ACME_ADDR_STATUS 8'h60
`define ACME_ADDR_CTRL 8'h61

// Timing
`define ACME_CLK_HZ 10000000
`define ACME_US_CYCLES ((`ACME_CLK_HZ) / 1000000)
`define ACME_MS_UNITS 1000

`endif

/* logic/acme_entry_cmp.v */
/*
 Compares one matching entry against the parsed header fields.
 Assumes header fields are stable and valid while hdr_valid is high.
*/
`timescale 1ns/1ps
`include "acme_consts.vh"

module acme_entry_cmp (
  input wire [`ACME_M_W-1:0] entry,
  input wire [47:0] hdr_dmac,
  input wire [47:0] hdr_smac,
  input wire [15:0] hdr_ethertype,
  input wire [31:0] hdr_dip,
  input wire [31:0] hdr_sip,
  input wire [7:0] hdr_ip_proto,
  input wire hdr_is_tcp,
  input wire hdr_is_udp,
  input wire [15:0] hdr_sport,
  input wire [15:0] hdr_dport,
  input wire [31:0] hdr_tcp_seq,
  input wire [7:0] hdr_tcp_flags,
  output reg hit,
  output wire count_entry,
  output wire count_qualify
);
  wire [1:0] layer = entry[`ACME_M_LAYER_HI:`ACME_M_LAYER_LO];
  wire [1:0] opt = entry[`ACME_M_OPT_HI:`ACME_M_OPT_LO];
  wire side = entry[`ACME_M_SIDE];
  wire pol = entry[`ACME_M_POL];
  wire [1:0] pcmode = entry[`ACME_M_PCMODE_HI:`ACME_M_PCMODE_LO];
  wire flag_en = entry[`ACME_M_FLAGEN];
  wire [47:0] fa = entry[`ACME_M_A_HI:`ACME_M_A_LO];
  wire [31:0] fb = entry[`ACME_M_B_HI:`ACME_M_B_LO];
  wire [31:0] fc = entry[`ACME_M_C_HI:`ACME_M_C_LO];
  wire [15:0] fd = entry[`ACME_M_D_HI:`ACME_M_D_LO];
  wire [15:0] pmax = fc[31:16];
  wire [15:0] pmin = fc[15:0];
  wire [7:0] proto = fd[15:8];
  wire [7:0] flag_val = fd[7:0];
  wire [7:0] flag_ign = fb[7:0];

  wire [47:0] pkt_mac = side ? hdr_smac : hdr_dmac;
  wire [31:0] pkt_ip = side ? hdr_sip : hdr_dip;
  wire [15:0] pkt_port = side ? hdr_sport : hdr_dport;
  wire mac_eq = (pkt_mac == fa);
  wire type_eq = (hdr_ethertype == fd);
  wire ip_mask_eq = ((pkt_ip ^ fb) & ~fc) == 32'h0000_0000;
  wire ip_pair_eq = (hdr_sip == fb) && (hdr_dip == fc);
  reg port_ok;
  always @* begin
    case (pcmode)
      `ACME_OPT_1: port_ok = (pkt_port == pmax) || (pkt_port == pmin);
      `ACME_OPT_2: port_ok = (pkt_port >= pmin) && (pkt_port <= pmax);
      `ACME_OPT_3: port_ok = (pkt_port < pmin) || (pkt_port > pmax);
      default: port_ok = 1'b1;
    endcase
  end
  wire flags_eq = !flag_en ||
    (((hdr_tcp_flags ^ flag_val) & ~flag_ign) == 8'h00);

  reg cmp;
  reg legal;
  always @* begin
    cmp = 1'b0;
    legal = 1'b1;
    case (layer)
      `ACME_LAYER_L2: begin
        case (opt)
          `ACME_OPT_1: cmp = mac_eq;
          `ACME_OPT_2: cmp = type_eq;
          default: cmp = mac_eq && type_eq;
        endcase
      end
      `ACME_LAYER_L3: begin
        case (opt)
          `ACME_OPT_1: cmp = ip_mask_eq;
          `ACME_OPT_2: cmp = ip_pair_eq;
          default: legal = 1'b0;
        endcase
      end
      `ACME_LAYER_L4: begin
        case (opt)
          `ACME_OPT_0: cmp = (hdr_ip_proto == proto);
          `ACME_OPT_1: cmp = hdr_is_tcp && port_ok && flags_eq;
          `ACME_OPT_2: cmp = hdr_is_udp && port_ok;
          default: cmp = hdr_is_tcp && (hdr_tcp_seq == fc) && flags_eq;
        endcase
      end
      default: legal = 1'b0;
    endcase
  end

  // counting qualifies on MAC and type
  assign count_entry = (layer == `ACME_LAYER_L2) && (opt == `ACME_OPT_0);
  assign count_qualify = count_entry && mac_eq && type_eq;

  always @* begin
    if (!legal || count_entry) begin
      hit = 1'b0;
    end else begin
      hit = pol ? cmp : !cmp;
    end
  end
endmodule

/* logic/acme_engine.v */
/*
 ACL match/action engine: 16 matching entries, 16 action entries,
 16 entry sets, per-entry count mode timers.
 Assumes a parser gives one header per hdr_valid pulse, and the
 forwarding datapath takes the answer on res_valid one cycle later.
*/
// Chosen here: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "acme_consts.vh"

module acme_engine #(
  parameter NPORTS = 3,
  parameter US_CYCLES = `ACME_US_CYCLES,
  parameter MS_UNITS = `ACME_MS_UNITS
) (
  input wire mclk,
  input wire sys_rst,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  input wire hdr_valid,
  input wire [NPORTS-1:0] hdr_port,
  input wire [47:0] hdr_dmac,
  input wire [47:0] hdr_smac,
  input wire [15:0] hdr_ethertype,
  input wire [31:0] hdr_dip,
  input wire [31:0] hdr_sip,
  input wire [7:0] hdr_ip_proto,
  input wire hdr_is_tcp,
  input wire hdr_is_udp,
  input wire [15:0] hdr_sport,
  input wire [15:0] hdr_dport,
  input wire [31:0] hdr_tcp_seq,
  input wire [7:0] hdr_tcp_flags,
  input wire [2:0] qos_prio,
  input wire [2:0] pkt_pcp,
  input wire [NPORTS-1:0] lookup_map,
  output reg res_valid,
  output reg res_hit,
  output reg [2:0] res_prio,
  output reg [2:0] res_pcp,
  output reg [NPORTS-1:0] res_map,
  output wire [NPORTS-1:0] count_irq
);
  localparam N = `ACME_ENTRIES;

  // -------------------------------------------------------------
  // Tables
  // -------------------------------------------------------------
  reg [`ACME_M_W-1:0] match_tab [0:N-1];
  reg [`ACME_A_W-1:0] action_tab [0:N-1];
  reg [NPORTS-1:0] fwd_tab [0:N-1];
  reg [15:0] set_mask [0:N-1];
  reg [3:0] set_first [0:N-1];
  reg [NPORTS-1:0] irq_stat;
  reg [NPORTS-1:0] irq_mask;
  wire [NPORTS-1:0] irq_set;

  // Entries 0-7 at 0x00-0x3F, 8-15 at 0x80-0xBF; 5 words at stride 8
  wire [3:0] m_idx = {reg_addr[7], reg_addr[5:3]};
  wire [2:0] m_word = reg_addr[2:0];
  wire [3:0] lo_idx = reg_addr[3:0];
  wire is_match = !reg_addr[6];
  wire is_action = (reg_addr[7:4] == `ACME_ADDR_ACTION >> 4);
  wire is_set = (reg_addr[7:4] == `ACME_ADDR_SET >> 4);

  integer i;
  always @(posedge mclk) begin
    if (sys_rst) begin
      for (i = 0; i < N; i = i + 1) begin
        match_tab[i] <= {`ACME_M_W{1'b0}};
        action_tab[i] <= {`ACME_A_W{1'b0}};
        fwd_tab[i] <= {NPORTS{1'b0}};
        set_mask[i] <= 16'h0000;
        set_first[i] <= 4'h0;
      end
      irq_mask <= {NPORTS{1'b0}};
    end else if (reg_wr) begin
      if (is_match && m_word < 3'd5) begin
        case (m_word)
          3'd0: match_tab[m_idx][31:0] <= reg_wdata;
          3'd1: match_tab[m_idx][63:32] <= reg_wdata;
          3'd2: match_tab[m_idx][95:64] <= reg_wdata;
          3'd3: match_tab[m_idx][127:96] <= reg_wdata;
          default: match_tab[m_idx][159:128] <= reg_wdata;
        endcase
      end else if (is_action) begin
        action_tab[lo_idx] <= reg_wdata[`ACME_A_W-1:0];
        fwd_tab[lo_idx] <= reg_wdata[31:32-NPORTS];
      end else if (is_set) begin
        set_mask[lo_idx] <= reg_wdata[15:0];
        set_first[lo_idx] <= reg_wdata[19:16];
      end else if (reg_addr == `ACME_ADDR_CTRL) begin
        irq_mask <= reg_wdata[NPORTS-1:0];
      end
    end
  end

  // Status: write one to clear; a new event in the same cycle wins
  always @(posedge mclk) begin
    if (sys_rst) begin
      irq_stat <= {NPORTS{1'b0}};
    end else begin
      irq_stat <= (irq_stat &
        ~((reg_wr && reg_addr == `ACME_ADDR_STATUS) ?
          reg_wdata[NPORTS-1:0] : {NPORTS{1'b0}})) | irq_set;
    end
  end
  assign count_irq = irq_stat & ~irq_mask;

  always @(posedge mclk) begin
    if (sys_rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      reg_rdata <= 32'h0000_0000;
      if (is_match && m_word < 3'd5) begin
        case (m_word)
          3'd0: reg_rdata <= match_tab[m_idx][31:0];
          3'd1: reg_rdata <= match_tab[m_idx][63:32];
          3'd2: reg_rdata <= match_tab[m_idx][95:64];
          3'd3: reg_rdata <= match_tab[m_idx][127:96];
          default: reg_rdata <= match_tab[m_idx][159:128];
        endcase
      end else if (is_action) begin
        reg_rdata <= {fwd_tab[lo_idx], {(32-NPORTS-`ACME_A_W){1'b0}},
          action_tab[lo_idx]};
      end else if (is_set) begin
        reg_rdata <= {12'h000, set_first[lo_idx], set_mask[lo_idx]};
      end else if (reg_addr == `ACME_ADDR_STATUS) begin
        reg_rdata <= {{(32-NPORTS){1'b0}}, irq_stat};
      end else if (reg_addr == `ACME_ADDR_CTRL) begin
        reg_rdata <= {{(32-NPORTS){1'b0}}, irq_mask};
      end
    end
  end

  // -------------------------------------------------------------
  // Entry compare
  // -------------------------------------------------------------
  wire [N-1:0] hit;
  wire [N-1:0] cnt_en;
  wire [N-1:0] cnt_q;
  genvar g;
  generate
    for (g = 0; g < N; g = g + 1) begin : g_ent
      acme_entry_cmp u_cmp (
        .entry(match_tab[g]),
        .hdr_dmac(hdr_dmac),
        .hdr_smac(hdr_smac),
        .hdr_ethertype(hdr_ethertype),
        .hdr_dip(hdr_dip),
        .hdr_sip(hdr_sip),
        .hdr_ip_proto(hdr_ip_proto),
        .hdr_is_tcp(hdr_is_tcp),
        .hdr_is_udp(hdr_is_udp),
        .hdr_sport(hdr_sport),
        .hdr_dport(hdr_dport),
        .hdr_tcp_seq(hdr_tcp_seq),
        .hdr_tcp_flags(hdr_tcp_flags),
        .hit(hit[g]),
        .count_entry(cnt_en[g]),
        .count_qualify(cnt_q[g])
      );
    end
  endgenerate

  // -------------------------------------------------------------
  // Set evaluation and action choice
  // -------------------------------------------------------------
  reg found;
  reg [3:0] best;
  integer s;
  always @* begin
    found = 1'b0;
    best = 4'hf;
    for (s = 0; s < N; s = s + 1) begin
      if (set_mask[s] != 16'h0000 &&
          (set_mask[s] & ~hit) == 16'h0000) begin
        if (!found || set_first[s] < best) begin
          best = set_first[s];
        end
        found = 1'b1;
      end
    end
  end

  wire [`ACME_A_W-1:0] act = action_tab[best];
  wire [1:0] pm = act[`ACME_A_PM_HI:`ACME_A_PM_LO];
  wire [2:0] ap = act[`ACME_A_P_HI:`ACME_A_P_LO];
  wire [1:0] mm = act[`ACME_A_MM_HI:`ACME_A_MM_LO];
  wire [NPORTS-1:0] amap = fwd_tab[best];

  reg [2:0] next_prio;
  reg [NPORTS-1:0] next_map;
  always @* begin
    next_prio = qos_prio;
    next_map = lookup_map;
    if (found) begin
      case (pm)
        `ACME_OPT_1: next_prio = (ap > qos_prio) ? ap : qos_prio;
        `ACME_OPT_2: next_prio = (ap < qos_prio) ? ap : qos_prio;
        `ACME_OPT_3: next_prio = ap;
        default: next_prio = qos_prio;
      endcase
      case (mm)
        `ACME_OPT_1: next_map = lookup_map | amap;
        `ACME_OPT_2: next_map = lookup_map & amap;
        `ACME_OPT_3: next_map = amap;
        default: next_map = lookup_map;
      endcase
    end
  end

  always @(posedge mclk) begin
    if (sys_rst) begin
      res_valid <= 1'b0;
      res_hit <= 1'b0;
      res_prio <= 3'h0;
      res_pcp <= 3'h0;
      res_map <= {NPORTS{1'b0}};
    end else begin
      res_valid <= hdr_valid;
      if (hdr_valid) begin
        res_hit <= found;
        res_prio <= next_prio;
        res_pcp <= (found && act[`ACME_A_RPE]) ?
          act[`ACME_A_RP_HI:`ACME_A_RP_LO] : pkt_pcp;
        res_map <= next_map;
      end
    end
  end

  // -------------------------------------------------------------
  // Count mode timers
  // -------------------------------------------------------------
  reg [15:0] us_div;
  reg [9:0] ms_div;
  wire us_tick = (us_div == US_CYCLES - 1);
  wire ms_tick = us_tick && (ms_div == MS_UNITS - 1);
  always @(posedge mclk) begin
    if (sys_rst) begin
      us_div <= 16'h0000;
      ms_div <= 10'h000;
    end else begin
      us_div <= us_tick ? 16'h0000 : us_div + 16'h0001;
      if (us_tick) begin
        ms_div <= ms_tick ? 10'h000 : ms_div + 10'h001;
      end
    end
  end

  reg [`ACME_CNT_W-1:0] cnt [0:N-1];
  reg [N-1:0] armed;
  reg [N-1:0] fire;
  wire pkt = hdr_valid;
  integer c;
  always @(posedge mclk) begin
    if (sys_rst) begin
      for (c = 0; c < N; c = c + 1) begin
        cnt[c] <= {`ACME_CNT_W{1'b0}};
      end
      armed <= {N{1'b0}};
      fire <= {N{1'b0}};
    end else begin
      for (c = 0; c < N; c = c + 1) begin
        fire[c] <= 1'b0;
        if (!cnt_en[c]) begin
          armed[c] <= 1'b0;
          cnt[c] <= {`ACME_CNT_W{1'b0}};
        end else if (!action_tab[c][`ACME_A_CA]) begin
          if (pkt && cnt_q[c]) begin
            cnt[c] <= action_tab[c][`ACME_A_CNT_HI:`ACME_A_CNT_LO];
            armed[c] <= 1'b1;
          end else if (armed[c] && (action_tab[c][`ACME_A_TU] ?
              ms_tick : us_tick)) begin
            if (cnt[c] <= 11'h001) begin
              armed[c] <= 1'b0;
              fire[c] <= 1'b1;
              cnt[c] <= 11'h000;
            end else begin
              cnt[c] <= cnt[c] - 11'h001;
            end
          end
        end else if (pkt && cnt_q[c]) begin
          // count up to terminal, then reset
          if (cnt[c] + 11'h001 >=
              action_tab[c][`ACME_A_CNT_HI:`ACME_A_CNT_LO]) begin
            cnt[c] <= 11'h000;
            fire[c] <= 1'b1;
          end else begin
            cnt[c] <= cnt[c] + 11'h001;
          end
        end
      end
    end
  end

  // Latch ingress port of the last qualifying packet per entry
  reg [NPORTS-1:0] owner [0:N-1];
  integer o;
  always @(posedge mclk) begin
    if (sys_rst) begin
      for (o = 0; o < N; o = o + 1) begin
        owner[o] <= {NPORTS{1'b0}};
      end
    end else begin
      for (o = 0; o < N; o = o + 1) begin
        if (pkt && cnt_q[o]) begin
          owner[o] <= hdr_port;
        end
      end
    end
  end

  // route each firing entry to its port
  reg [NPORTS-1:0] next_irq;
  integer k;
  always @* begin
    next_irq = {NPORTS{1'b0}};
    for (k = 0; k < N; k = k + 1) begin
      if (fire[k]) begin
        next_irq = next_irq | owner[k];
      end
    end
  end
  assign irq_set = next_irq;
endmodule

/* testbench/acme_engine_sva.sv */
/*
 Port checker for acme_engine: result timing, hold, pass-through,
 reset state and interrupt clearing.
 Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module acme_engine_sva #(
  parameter NPORTS = 3
) (
  input wire mclk,
  input wire sys_rst,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_rdata,
  input wire hdr_valid,
  input wire [2:0] qos_prio,
  input wire [2:0] pkt_pcp,
  input wire [NPORTS-1:0] lookup_map,
  input wire res_valid,
  input wire res_hit,
  input wire [2:0] res_prio,
  input wire [2:0] res_pcp,
  input wire [NPORTS-1:0] res_map,
  input wire [NPORTS-1:0] count_irq
);
  // --------------------------------------------------------------
  // Port relations
  // --------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  a_res_timing: assert property (
    !$past(sys_rst) |-> res_valid == $past(hdr_valid))
    else $error("result strobe not one cycle after header");
  a_res_hold: assert property (
    !res_valid && !$past(sys_rst) |-> $stable(res_hit) && $stable(res_prio)
    && $stable(res_pcp) && $stable(res_map))
    else $error("result changed without a strobe");
  a_miss_passthru: assert property (
    res_valid && !res_hit |-> res_prio == $past(qos_prio)
    && res_pcp == $past(pkt_pcp) && res_map == $past(lookup_map))
    else $error("missed packet did not pass values through");
  a_reset_clears: assert property (
    $fell(sys_rst) |-> !res_valid && !res_hit && count_irq == '0
    && reg_rdata == 32'h0000_0000 && res_map == '0)
    else $error("outputs not cleared by reset");
  a_rdata_hold: assert property (
    !$past(reg_rd) && !$past(sys_rst) |-> $stable(reg_rdata))
    else $error("read data changed without a read");
  a_irq_clear: assert property (
    (|($past(count_irq) & ~count_irq)) && !$past(sys_rst) |->
    $past(reg_wr) && ($past(reg_addr) == 8'h60 || $past(reg_addr) == 8'h61))
    else $error("interrupt dropped without a status or mask write");
  a_irq_masked: assert property (
    reg_wr && reg_addr == 8'h61 && (&reg_wdata[NPORTS-1:0]) |=>
    count_irq == '0)
    else $error("interrupt seen while fully masked");
  a_unmapped_zero: assert property (
    reg_rd && reg_addr[7:6] == 2'h3 |=> reg_rdata == 32'h0000_0000)
    else $error("unmapped read returned nonzero");
endmodule

/* testbench/acme_fwd_model.sv */
/*
 Forwarding-side model: takes each engine result at its strobe and
 counts them. Assumes results arrive as single-cycle strobes.
*/
`timescale 1ns/1ps
module acme_fwd_model #(
  parameter NPORTS = 3
) (
  input wire mclk,
  input wire sys_rst,
  input wire res_valid,
  input wire res_hit,
  input wire [2:0] res_prio,
  input wire [2:0] res_pcp,
  input wire [NPORTS-1:0] res_map,
  output reg [6+NPORTS:0] taken,
  output reg [15:0] num_taken
);
  // --------------------------------------------------------------
  // Capture
  // --------------------------------------------------------------
  // Only the strobe cycle is trusted, so stale values never leak in
  always @(posedge mclk) begin
    if (sys_rst) begin
      taken <= '0;
      num_taken <= 16'h0000;
    end else if (res_valid) begin
      taken <= {res_hit, res_prio, res_pcp, res_map};
      num_taken <= num_taken + 16'h0001;
    end
  end
endmodule

/* testbench/acme_engine_test.sv */
/*
 Self-checking bench for acme_engine with the forwarding model.
 Assumes the plain register port and shortened timer counts.
*/
`timescale 1ns/1ps
module acme_engine_test;
  localparam NP = 3;
  localparam US = 2;
  localparam MS = 4;
  localparam [47:0] DM = 48'h0011_2233_4455;
  localparam [47:0] SM = 48'h6677_8899_aabb;
  localparam [31:0] DIP = 32'hc0a8_0001;
  localparam [31:0] SIP = 32'h0a00_0005;
  localparam [31:0] SEQ = 32'h1234_5678;
  reg mclk, sys_rst, reg_wr, reg_rd, hdr_valid, is_tcp, is_udp;
  reg [7:0] reg_addr, proto, flags;
  reg [31:0] reg_wdata, dip, sip, seq, rv;
  reg [47:0] dmac, smac;
  reg [15:0] ethertype, sport, dport;
  reg [2:0] qos_prio, pkt_pcp, ep;
  reg [NP-1:0] hdr_port, lookup_map, em;
  reg [160:0] rows [0:23];
  wire [31:0] reg_rdata;
  wire res_valid, res_hit;
  wire [2:0] res_prio, res_pcp;
  wire [NP-1:0] res_map, count_irq;
  wire [6+NP:0] taken;
  wire [15:0] num_taken;
  integer num_errors, tests_run, npk, r, k, t, u;

  acme_engine #(.NPORTS(NP), .US_CYCLES(US), .MS_UNITS(MS)) dut (
    .mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .hdr_valid(hdr_valid), .hdr_port(hdr_port),
    .hdr_dmac(dmac), .hdr_smac(smac), .hdr_ethertype(ethertype),
    .hdr_dip(dip), .hdr_sip(sip), .hdr_ip_proto(proto),
    .hdr_is_tcp(is_tcp), .hdr_is_udp(is_udp), .hdr_sport(sport),
    .hdr_dport(dport), .hdr_tcp_seq(seq), .hdr_tcp_flags(flags),
    .qos_prio(qos_prio), .pkt_pcp(pkt_pcp), .lookup_map(lookup_map),
    .res_valid(res_valid), .res_hit(res_hit), .res_prio(res_prio),
    .res_pcp(res_pcp), .res_map(res_map), .count_irq(count_irq));
  acme_fwd_model #(.NPORTS(NP)) fwd (
    .mclk(mclk), .sys_rst(sys_rst), .res_valid(res_valid),
    .res_hit(res_hit), .res_prio(res_prio), .res_pcp(res_pcp),
    .res_map(res_map), .taken(taken), .num_taken(num_taken));

  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  function [159:0] ent(input [1:0] ly, input [1:0] op, input sd,
    input pl, input [1:0] pc, input fe, input [47:0] mac,
    input [31:0] b, input [31:0] c, input [15:0] d);
    ent = {ly, op, sd, pl, pc, fe, 23'h00_0000, mac, b, c, d};
  endfunction
  function [31:0] act(input [1:0] pm, input [2:0] p, input re,
    input [2:0] rp, input [1:0] mm, input [NP-1:0] map);
    act = {map, 5'h00, pm, p, re, rp, mm, 13'h0000};
  endfunction
  function [31:0] cact(input [10:0] c, input tu, input ca);
    cact = {8'h00, c, tu, ca, 11'h000};
  endfunction
  task chk(input [31:0] got, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, output [31:0] d);
    begin
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
    end
  endtask
  task wr_ent(input [3:0] i, input [159:0] e);
    integer w;
    begin
      for (w = 0; w < 5; w = w + 1)
        wr({i[3], 1'b0, i[2:0], 3'h0} + w, e[32*w +: 32]);
    end
  endtask
  task pkt(input [NP-1:0] p);
    begin
      @(posedge mclk);
      hdr_port <= p;
      hdr_valid <= 1'b1;
      @(posedge mclk);
      hdr_valid <= 1'b0;
      @(posedge mclk);
      #1;
      npk = npk + 1;
    end
  endtask
  // Quiet for lo cycles, then the expected bits within hi cycles
  task wait_irq(input [NP-1:0] e, input integer lo, input integer hi);
    integer n;
    begin
      for (n = 0; n < lo; n = n + 1) begin
        @(posedge mclk);
        #1;
        if (count_irq !== '0)
          chk(count_irq, 0);
      end
      for (n = 0; n < hi && count_irq !== e; n = n + 1) begin
        @(posedge mclk);
        #1;
      end
      chk(count_irq, e);
    end
  endtask
  task results;
    begin
      $display("TB: errors=%0d checks=%0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask

  // --------------------------------------------------------------
  // Clock, watchdog, sequence
  // --------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  initial begin
    #(100 * 20000);
    num_errors = num_errors + 1;
    results;
  end
  initial begin
    {dmac, smac, dip, sip, seq} = {DM, SM, DIP, SIP, SEQ};
    {proto, flags, sport, dport} = {8'h06, 8'h12, 16'h1f90, 16'h0050};
    {is_tcp, is_udp, reg_wr, reg_rd, hdr_valid} = 5'h10;
    {reg_addr, reg_wdata, ethertype} = {8'h00, 32'h0000_0000, 16'h0800};
    {qos_prio, pkt_pcp, hdr_port, lookup_map} = 12'h68b;
    {num_errors, tests_run, npk} = 0;
    sys_rst = 1'b1;
    rows[0] = {ent(1, 1, 0, 1, 0, 0, DM, 0, 0, 0), 1'b1};
    rows[1] = {ent(1, 1, 1, 1, 0, 0, DM, 0, 0, 0), 1'b0};
    rows[2] = {ent(1, 1, 0, 0, 0, 0, DM, 0, 0, 0), 1'b0};
    rows[3] = {ent(1, 2, 0, 1, 0, 0, 0, 0, 0, 16'h0800), 1'b1};
    rows[4] = {ent(1, 3, 1, 1, 0, 0, SM, 0, 0, 16'h0806), 1'b0};
    rows[5] = {ent(1, 3, 1, 1, 0, 0, SM, 0, 0, 16'h0800), 1'b1};
    rows[6] = {ent(0, 1, 0, 1, 0, 0, DM, 0, 0, 0), 1'b0};
    rows[7] = {ent(2, 1, 0, 1, 0, 0, 0, 32'hc0a8_00ff, 32'h0000_00ff, 0),
      1'b1};
    rows[8] = {ent(2, 1, 0, 1, 0, 0, 0, 32'hc0a8_00ff, 32'h0000_000f, 0),
      1'b0};
    rows[9] = {ent(2, 1, 1, 1, 0, 0, 0, SIP, 0, 0), 1'b1};
    rows[10] = {ent(2, 2, 0, 1, 0, 0, 0, SIP, DIP, 0), 1'b1};
    rows[11] = {ent(2, 2, 0, 1, 0, 0, 0, DIP, SIP, 0), 1'b0};
    rows[12] = {ent(2, 0, 0, 0, 0, 0, 0, 0, 0, 0), 1'b0};
    rows[13] = {ent(2, 3, 0, 0, 0, 0, 0, 0, 0, 0), 1'b0};
    rows[14] = {ent(3, 0, 0, 1, 0, 0, 0, 0, 0, 16'h0600), 1'b1};
    rows[15] = {ent(3, 0, 0, 1, 0, 0, 0, 0, 0, 16'h1100), 1'b0};
    rows[16] = {ent(3, 1, 0, 1, 1, 0, 0, 0, 32'h0050_0001, 0), 1'b1};
    rows[17] = {ent(3, 1, 0, 1, 2, 0, 0, 0, 32'h0060_0040, 0), 1'b1};
    rows[18] = {ent(3, 1, 0, 1, 3, 0, 0, 0, 32'h0060_0040, 0), 1'b0};
    rows[19] = {ent(3, 1, 1, 1, 2, 0, 0, 0, 32'h0060_0040, 0), 1'b0};
    rows[20] = {ent(3, 2, 0, 1, 1, 0, 0, 0, 32'h0050_0001, 0), 1'b0};
    rows[21] = {ent(3, 3, 0, 1, 0, 0, 0, 0, SEQ, 0), 1'b1};
    rows[22] = {ent(3, 1, 0, 1, 0, 1, 0, 32'h0000_0002, 0, 16'h0010), 1'b1};
    rows[23] = {ent(3, 1, 0, 1, 0, 1, 0, 0, 0, 16'h0010), 1'b0};
    repeat (6) @(posedge mclk);
    sys_rst <= 1'b0;
    wr(8'h50, 32'h0000_0001);
    wr(8'h40, act(3, 5, 1, 6, 1, 3'h4));
    for (r = 0; r < 24; r = r + 1) begin
      wr_ent(0, rows[r][160:1]);
      pkt(3'h1);
      chk(taken, rows[r][0] ? 10'h377 : 10'h0d3);
    end
    chk(count_irq, 0);
    wr_ent(0, rows[0][160:1]);
    wr_ent(1, rows[1][160:1]);
    wr(8'h50, 32'h0000_0003);
    pkt(3'h1);
    chk(taken[6+NP], 0);
    wr_ent(9, rows[5][160:1]);
    wr(8'h50, 32'h0000_0201);
    pkt(3'h1);
    chk(taken[6+NP], 1);
    wr(8'h50, 32'h0002_0001);
    wr(8'h51, 32'h0001_0200);
    wr(8'h42, act(3, 7, 0, 0, 3, 3'h0));
    for (k = 0; k < 4; k = k + 1) begin
      for (t = 0; t < 2; t = t + 1) begin
        wr(8'h41, act(k, 3, k[0], 6, k, 3'h6));
        qos_prio <= 1 + 4 * t;
        ep = (k == 0) ? 1 + 4 * t : (k == 1) ? 3 + 2 * t : 1 + 2 * t;
        ep = (k == 3) ? 3'h3 : ep;
        em = (k == 0) ? 3'h3 : (k == 1) ? 3'h7 : (k == 2) ? 3'h2 : 3'h6;
        pkt(3'h1);
        chk(taken, {1'b1, ep, k[0] ? 3'h6 : 3'h2, em});
      end
    end
    wr(8'h51, 32'h0000_0000);
    qos_prio <= 3'h1;
    wr(8'h50, 32'h0000_0004);
    wr_ent(2, ent(1, 0, 0, 1, 0, 0, DM, 0, 0, 16'h0800));
    wr(8'h42, cact(3, 0, 1));
    for (r = 0; r < 4; r = r + 1) begin
      ethertype <= (r == 2) ? 16'h0806 : 16'h0800;
      pkt(3'h2);
      chk(taken[6+NP], 0);
      repeat (3) @(posedge mclk);
      chk(count_irq, (r == 3) ? 3'h2 : 3'h0);
    end
    rd(8'h60, rv);
    chk(rv, 32'h0000_0002);
    wr(8'h61, 32'h0000_0007);
    #1;
    chk(count_irq, 0);
    wr(8'h61, 32'h0000_0000);
    #1;
    chk(count_irq, 3'h2);
    wr(8'h60, 32'h0000_0002);
    #1;
    chk(count_irq, 0);
    rd(8'hc0, rv);
    chk(rv, 0);
    wr(8'h50, 32'h0000_0000);
    wr_ent(2, 160'h0);
    wr_ent(3, ent(1, 0, 0, 1, 0, 0, DM, 0, 0, 16'h0800));
    for (t = 0; t < 2; t = t + 1) begin
      u = US * (t ? MS : 1);
      wr(8'h43, cact(6, t, 0));
      pkt(3'h1);
      repeat (2 * u) @(posedge mclk);
      pkt(3'h1);
      wait_irq(3'h1, 5 * u - 2, u + 6);
      if (t == 0)
        wr(8'h60, 32'h0000_0001);
    end
    chk(num_taken, npk);
    @(posedge mclk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    #1;
    chk(count_irq, 0);
    rd(8'h60, rv);
    chk(rv, 0);
    results;
  end
endmodule

bind acme_engine acme_engine_sva #(.NPORTS(NPORTS)) sva (
  .mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .hdr_valid(hdr_valid), .qos_prio(qos_prio),
  .pkt_pcp(pkt_pcp), .lookup_map(lookup_map), .res_valid(res_valid),
  .res_hit(res_hit), .res_prio(res_prio), .res_pcp(res_pcp),
  .res_map(res_map), .count_irq(count_irq));
